// ### shared/sfpi_pkg.sv
// shared constants for the serial flash pin interface block
// assumes one 40 MHz core clock; all pins are sampled by that clock
package sfpi_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] SFPI_OFF_CTRL   = 8'h00;
    localparam logic [7:0] SFPI_OFF_LANE   = 8'h04;
    localparam logic [7:0] SFPI_OFF_TXDATA = 8'h08;
    localparam logic [7:0] SFPI_OFF_RXDATA = 8'h0C;
    localparam logic [7:0] SFPI_OFF_STATUS = 8'h10;
    localparam logic [7:0] SFPI_OFF_OPCTL  = 8'h14;

    // control register fields
    localparam int SFPI_CTRL_QE  = 0;   // quad_io_enable
    localparam int SFPI_CTRL_SPL = 1;   // status_protect_lo
    localparam int SFPI_CTRL_SPH = 2;   // status_protect_hi
    localparam int SFPI_CTRL_HRS = 3;   // hold_reset_select, 1 = reset
    localparam int SFPI_CTRL_DPD = 4;   // deep power-down request
    localparam logic [4:0] SFPI_CTRL_RST = 5'h00;

    // lane register fields
    localparam int SFPI_LANE_W0  = 0;   // width code, two bits
    localparam int SFPI_LANE_OUT = 2;   // data output phase
    localparam logic [2:0] SFPI_LANE_RST = 3'h0;

    // opctl write bits
    localparam int SFPI_OP_START = 0;
    localparam int SFPI_OP_DONE  = 1;

    // status register fields
    localparam int SFPI_ST_SEL   = 0;
    localparam int SFPI_ST_STBY  = 1;
    localparam int SFPI_ST_DPD   = 2;
    localparam int SFPI_ST_BUSY  = 3;
    localparam int SFPI_ST_WPB   = 4;
    localparam int SFPI_ST_HOLD  = 5;
    localparam int SFPI_ST_PRST  = 6;

    // lane width codes
    localparam logic [1:0] SFPI_W_SINGLE = 2'h0;
    localparam logic [1:0] SFPI_W_DUAL   = 2'h1;
    localparam logic [1:0] SFPI_W_QUAD   = 2'h2;

    localparam logic [3:0] SFPI_BYTE_BITS = 4'h8;
    localparam int         SFPI_SYNC_W    = 6;

    typedef enum logic [1:0] {
        SFPI_STANDBY = 2'b00,
        SFPI_ACTIVE  = 2'b01,
        SFPI_BUSYW   = 2'b10,
        SFPI_DPD     = 2'b11
    } sfpi_state_t;

endpackage

// ### rtl/sfpi_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk; only stage two is visible
`timescale 1ns/1ps
`default_nettype none
module sfpi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ------------------------------------------------------------
    // per-bit flop pair
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q;
            // stage one is read by stage two only
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b1;
                    q[i] <= 1'b1;
                end else begin
                    s1_q <= d[i];
                    q[i] <= s1_q;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### rtl/sfpi_top.sv
// pin-level front end of a serial flash: framing, shifting, lane control
// assumes the core drives the register port on ref_clk; the bench resolves pins
//
// Function
// - cs falling starts, rising ends every operation
// - deselected: outputs released, input data discarded
// - deselect enters standby, or deep power-down when requested
// - busy internal operation delays standby entry
// - input bits sampled on rising clock edge
// - output data updated on falling clock edge
// - multi-io read drives io0 with other lanes
// - so carries lane one, shifts together
// - wp low blocks status writes when configured
// - quad enabled: pin two is data lane
// - floating write protect reads as deasserted
// - quad disabled: pin three is hold or reset
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sfpi_top
    import sfpi_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic [3:0] io_in,
    output logic      [3:0] io_out,
    output logic      [3:0] io_oe,
    output logic            standby,
    input  wire logic [7:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [31:0] rdata
);
    import sfpi_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pin_s;
    sfpi_sync #(.W(SFPI_SYNC_W)) u_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({io_in, sck, cs_n}),
        .q   (pin_s)
    );

    wire cs_n_s = pin_s[0];
    wire sck_s  = pin_s[1];
    wire si_s   = pin_s[2];
    wire wp_n_s = pin_s[4];   // pull-up keeps a floating pin high
    wire p3_s   = pin_s[5];

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    sfpi_state_t state_q, state_d;
    logic        sck_prev_q;
    logic        cs_prev_q;
    logic [4:0]  ctrl_q;
    logic [2:0]  lane_q;
    logic [7:0]  tx_data_q;
    logic [7:0]  rx_byte_q;
    logic [7:0]  rx_sh_q;
    logic [3:0]  rx_cnt_q;
    logic [7:0]  tx_sh_q;
    logic [3:0]  tx_left_q;
    logic        busy_q;
    logic        hold_q;
    logic        wpb_q;
    logic        prst_q;

    // ------------------------------------------------------------
    // edge detection and pin roles
    // ------------------------------------------------------------
    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    wire cs_fall  = ~cs_n_s & cs_prev_q;
    wire cs_rise  = cs_n_s & ~cs_prev_q;
    wire qe       = ctrl_q[SFPI_CTRL_QE];
    wire hrs      = ctrl_q[SFPI_CTRL_HRS];
    wire dpd_req  = ctrl_q[SFPI_CTRL_DPD];
    wire sel      = (state_q == SFPI_ACTIVE);
    wire out_ph   = lane_q[SFPI_LANE_OUT];
    // pin three acts as reset only with quad off and reset chosen
    wire pin_rst  = ~qe & hrs & ~p3_s;
    wire hold_on  = ~qe & ~hrs & ~p3_s & ~sck_s & sel;
    wire hold_off = (p3_s | qe | hrs) & ~sck_s;
    // write protect matters only in one protect setting, never with quad on
    wire wpb_d    = ~qe & ~ctrl_q[SFPI_CTRL_SPH]
                  & ctrl_q[SFPI_CTRL_SPL] & ~wp_n_s;

    // ------------------------------------------------------------
    // lane width: quad falls back to dual while quad is disabled
    // ------------------------------------------------------------
    wire [1:0] wcode = lane_q[SFPI_LANE_W0 +: 2];
    wire       w_quad = (wcode == SFPI_W_QUAD) & qe;
    wire       w_dual = (wcode == SFPI_W_DUAL) | ((wcode == SFPI_W_QUAD) & ~qe);
    wire [3:0] step   = w_quad ? 4'h4 : (w_dual ? 4'h2 : 4'h1);
    wire [3:0] lane_m = w_quad ? 4'hF : (w_dual ? 4'h3 : 4'h2);

    // ------------------------------------------------------------
    // shift enables
    // ------------------------------------------------------------
    wire rx_en = sel & ~out_ph & ~hold_q;
    wire tx_en = sel & out_ph & ~hold_q;
    wire [7:0] tx_src = (tx_left_q == 4'h0) ? tx_data_q : tx_sh_q;
    wire [7:0] tx_nx  = w_quad ? {tx_src[3:0], 4'h0}
                      : (w_dual ? {tx_src[5:0], 2'h0} : {tx_src[6:0], 1'b0});
    wire [3:0] tx_lnx = ((tx_left_q == 4'h0) ? SFPI_BYTE_BITS : tx_left_q) - step;
    wire [3:0] out_d  = w_quad ? tx_src[7:4]
                      : (w_dual ? {2'h0, tx_src[7:6]} : {2'h0, tx_src[7], 1'b0});

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire wr_ctrl = wr & (addr == SFPI_OFF_CTRL);
    wire wr_lane = wr & (addr == SFPI_OFF_LANE);
    wire wr_tx   = wr & (addr == SFPI_OFF_TXDATA);
    wire wr_op   = wr & (addr == SFPI_OFF_OPCTL);
    wire [31:0] status_w = {25'h0, prst_q, hold_q, wpb_q, busy_q,
                            state_q == SFPI_DPD, state_q == SFPI_STANDBY, sel};
    logic [31:0] rd_mux;
    always_comb begin
        if (addr == SFPI_OFF_CTRL) begin
            rd_mux = {27'h0, ctrl_q};
        end else if (addr == SFPI_OFF_LANE) begin
            rd_mux = {29'h0, lane_q};
        end else if (addr == SFPI_OFF_TXDATA) begin
            rd_mux = {24'h0, tx_data_q};
        end else if (addr == SFPI_OFF_RXDATA) begin
            rd_mux = {24'h0, rx_byte_q};
        end else if (addr == SFPI_OFF_STATUS) begin
            rd_mux = status_w;
        end else begin
            rd_mux = 32'h0;   // unmapped reads return zero
        end
    end

    // ------------------------------------------------------------
    // framing state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SFPI_STANDBY, SFPI_DPD: begin
                if (cs_fall) begin
                    state_d = SFPI_ACTIVE;
                end
            end
            SFPI_ACTIVE: begin
                if (cs_rise) begin
                    if (busy_q) begin
                        state_d = SFPI_BUSYW;
                    end else if (dpd_req) begin
                        state_d = SFPI_DPD;
                    end else begin
                        state_d = SFPI_STANDBY;
                    end
                end
            end
            SFPI_BUSYW: begin
                if (cs_fall) begin
                    state_d = SFPI_ACTIVE;   // status polling mid-operation
                end else if (!busy_q) begin
                    state_d = dpd_req ? SFPI_DPD : SFPI_STANDBY;
                end
            end
            default: state_d = SFPI_STANDBY;
        endcase
        if (pin_rst) begin
            state_d = SFPI_STANDBY;
        end
    end

    // state, edge history and status flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q    <= SFPI_STANDBY;
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
            wpb_q      <= 1'b0;
            prst_q     <= 1'b0;
            standby    <= 1'b1;
        end else begin
            state_q    <= state_d;
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
            wpb_q      <= wpb_d;
            prst_q     <= pin_rst;
            standby    <= (state_d == SFPI_STANDBY);
        end
    end

    // hold pauses shifting; entry and exit only while sck is low, deselect clears it at any time
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b0;
        end else if (!sel) begin
            hold_q <= 1'b0;
        end else if (hold_on) begin
            hold_q <= 1'b1;
        end else if (hold_off) begin
            hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // software registers; a start beats a done in the same write
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q    <= SFPI_CTRL_RST;
            lane_q    <= SFPI_LANE_RST;
            tx_data_q <= 8'h00;
            busy_q    <= 1'b0;
            rdata     <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= wdata[4:0];
            if (wr_lane) lane_q <= wdata[2:0];
            if (wr_tx) tx_data_q <= wdata[7:0];
            if (wr_op && wdata[SFPI_OP_START]) begin
                busy_q <= 1'b1;
            end else if (wr_op && wdata[SFPI_OP_DONE]) begin
                busy_q <= 1'b0;
            end
            rdata <= rd ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // receive shifter: sampled on rising sck, dropped when deselected
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_sh_q   <= 8'h00;
            rx_cnt_q  <= 4'h0;
            rx_byte_q <= 8'h00;
        end else if (!sel) begin
            rx_cnt_q <= 4'h0;
        end else if (rx_en && sck_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], si_s};
            if (rx_cnt_q == SFPI_BYTE_BITS - 4'h1) begin
                rx_byte_q <= {rx_sh_q[6:0], si_s};
                rx_cnt_q  <= 4'h0;
            end else begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit shifter: lanes change on falling sck only
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_sh_q   <= 8'h00;
            tx_left_q <= 4'h0;
            io_out    <= 4'h0;
        end else if (!tx_en && !hold_q) begin
            tx_left_q <= 4'h0;   // next data phase starts a fresh byte
        end else if (tx_en && sck_fall) begin
            io_out    <= out_d;
            tx_sh_q   <= tx_nx;
            tx_left_q <= tx_lnx;
        end
    end

    // enables released on the clock after deselect, or outside data phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_oe <= 4'h0;
        end else begin
            io_oe <= (sel && out_ph) ? lane_m : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_frame_start;
        (state_q == SFPI_STANDBY) && cs_fall && !pin_rst |=> sel;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame not opened");

    property p_release;
        !sel |=> (io_oe == 4'h0);
    endproperty
    a_release: assert property (p_release) else $error("lanes driven while deselected");

    property p_standby;
        sel && cs_rise && !busy_q && !dpd_req && !pin_rst |=> ##1 standby;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby after deselect");

    property p_busy_wait;
        sel && cs_rise && busy_q && !pin_rst |=> (state_q == SFPI_BUSYW) && !standby [*2];
    endproperty
    a_busy_wait: assert property (p_busy_wait) else $error("standby during busy");

    property p_rx_sample;
        rx_en && sck_rise |=> rx_sh_q[0] == $past(si_s);
    endproperty
    a_rx_sample: assert property (p_rx_sample) else $error("input bit not sampled");

    property p_tx_single;
        tx_en && sck_fall && (step == 4'h1) |=> io_out[1] == $past(tx_src[7]);
    endproperty
    a_tx_single: assert property (p_tx_single) else $error("so not updated");

    property p_tx_multi;
        tx_en && sck_fall && (step != 4'h1)
            |=> io_out[1:0] == ($past(w_quad) ? $past(tx_src[5:4]) : $past(tx_src[7:6]));
    endproperty
    a_tx_multi: assert property (p_tx_multi) else $error("lanes zero and one wrong");

    property p_oe_lanes;
        sel && out_ph && w_dual ##1 sel |-> io_oe == 4'h3;
    endproperty
    a_oe_lanes: assert property (p_oe_lanes) else $error("dual lanes not enabled");

    property p_wp_block;
        !qe && !ctrl_q[SFPI_CTRL_SPH] && ctrl_q[SFPI_CTRL_SPL] && !wp_n_s |=> wpb_q;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("protect not applied");

    property p_wp_quad;
        qe |=> !wpb_q;
    endproperty
    a_wp_quad: assert property (p_wp_quad) else $error("protect active in quad");

    property p_pin_reset;
        pin_rst |=> (state_q == SFPI_STANDBY) ##1 standby;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");

    property p_no_phase;
        !out_ph |=> (io_oe == 4'h0);
    endproperty
    a_no_phase: assert property (p_no_phase) else $error("lanes driven outside data");

    c_frame: cover property (sel && cs_rise);
    c_quad:  cover property (tx_en && sck_fall && w_quad);
    c_busyw: cover property (state_q == SFPI_BUSYW ##1 state_q == SFPI_STANDBY);
    c_hold:  cover property (hold_q);
endmodule
`default_nettype wire

// ### test/sfpi_host_model.sv
// host controller model: chip select, serial clock and host lane drivers
// assumes the bench calls its tasks in order; pins resolved here for all parties
`timescale 1ns/1ps
`default_nettype none
module sfpi_host_model (
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe,
    output logic            cs_n,
    output logic            sck,
    output logic      [3:0] pins
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    logic [3:0] drv_v  = 4'h0;
    logic [3:0] drv_oe = 4'h0;
    logic       tick   = 1'b0;

    initial cs_n = 1'b1;
    initial sck = 1'b0;

    // released lanes zero and one wobble so a stale level is never mistaken for data
    always #25 tick = ~tick;

    // device drive wins, then host, then pull-ups on lanes two and three
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dev_oe[i])
                pins[i] = dev_out[i];
            else if (drv_oe[i])
                pins[i] = drv_v[i];
            else
                pins[i] = (i > 1) ? 1'b1 : (tick ^ i[0]);
        end
    end

    // ------------------------------------------------------------
    // host actions
    // ------------------------------------------------------------
    task automatic drive(input logic [3:0] v, input logic [3:0] oe);
        drv_v = v;
        drv_oe = oe;
    endtask

    // odd offset keeps the link unrelated in phase to the core clock
    task automatic open_frame;
        #3 cs_n = 1'b0;
        #150;
    endtask

    task automatic close_frame;
        #150 cs_n = 1'b1;
        #150;
    endtask

    // one 200 ns clock; sampled late in the high phase to allow for the pin synchroniser
    task automatic pulse(output logic [3:0] s);
        #100 sck = 1'b1;
        #100 s = pins;
        sck = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### test/tb_sfpi_top.sv
// self-checking bench for the serial flash pin front end
// assumes the host model resolves pins; register port driven on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tb_sfpi_top;
    import sfpi_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        cs_n;
    logic        sck;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        standby;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [7:0]  b;
    logic [7:0]  got;
    logic [4:0]  c;
    logic        wp;
    logic        fl;
    int          errors  = 0;
    int          checks  = 0;
    int          seed    = 21576;

    always #12.5 ref_clk = ~ref_clk;

    sfpi_top uut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .standby(standby), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));

    sfpi_host_model host (.dev_out(io_out), .dev_oe(io_oe), .cs_n(cs_n), .sck(sck), .pins(io_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wcyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // bounded wait for standby to come back
    task automatic wait_stby;
        for (int i = 0; i < 12 && standby !== 1'b1; i++)
            @(posedge ref_clk);
    endtask

    task automatic send_byte(input logic [7:0] d);
        logic [3:0] s;
        #5;   // keeps host pin edges off the core clock edges
        for (int i = 7; i >= 0; i--) begin
            host.drive({3'h0, d[i]}, 4'h1);
            host.pulse(s);
        end
        host.drive(4'h0, 4'h0);
    endtask

    // first fall launches the top group, so one extra clock leads
    task automatic recv_byte(input int nb, output logic [7:0] d);
        logic [3:0] s;
        d = 8'h00;
        #5;
        host.pulse(s);
        for (int g = 0; g < 8 / nb; g++) begin
            host.pulse(s);
            d = (nb == 1) ? {d[6:0], s[1]} : (nb == 2) ? {d[5:0], s[1:0]} : {d[3:0], s};
        end
    endtask

    function automatic logic [3:0] exp_oe(input logic [1:0] w, input logic qe);
        if (w == SFPI_W_QUAD && qe)
            return 4'hF;
        if (w != SFPI_W_SINGLE)
            return 4'h3;
        return 4'h2;
    endfunction

    function automatic logic exp_wpb(input logic [4:0] k, input logic pin);
        return !k[0] && !k[2] && k[1] && !pin;
    endfunction

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog sized well past the expected run
    initial begin
        #1000000;
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        wcyc(16);
        rst <= 1'b0;
        wcyc(2);
        check("io_oe", io_oe, 32'h0);
        check("standby", standby, 32'h1);
        rreg(SFPI_OFF_CTRL, v);
        check("ctrl", v, {27'h0, SFPI_CTRL_RST});
        rreg(SFPI_OFF_LANE, v);
        check("lane", v, {29'h0, SFPI_LANE_RST});
        rreg(8'h3C, v);
        check("unmapped", v, 32'h0);
        rreg(SFPI_OFF_STATUS, v);
        check("status rst", v, 32'h1 << SFPI_ST_STBY);
        // read data must fall back to zero one cycle after it stood
        wcyc(1);
        #1 check("rdata idle", rdata, 32'h0);
        // input bytes inside a frame
        host.open_frame();
        wcyc(4);
        check("standby sel", standby, 32'h0);
        for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'h80 : 8'($random(seed));
            send_byte(b);
            rreg(SFPI_OFF_RXDATA, v);
            check("rxdata", v, {24'h0, b});
            check("io_oe in", io_oe, 32'h0);
        end
        host.close_frame();
        wait_stby();
        check("standby end", standby, 32'h1);
        // deselected traffic must be discarded
        send_byte(~b);
        rreg(SFPI_OFF_RXDATA, v);
        check("rx desel", v, {24'h0, b});
        check("io_oe desel", io_oe, 32'h0);
        // output in every width, with and without quad enable
        for (int w = 0; w < 3; w++) begin
            for (int q = 0; q < 2; q++) begin
                wreg(SFPI_OFF_CTRL, 32'(q));
                b = 8'($random(seed));
                wreg(SFPI_OFF_TXDATA, {24'h0, b});
                host.open_frame();
                wreg(SFPI_OFF_LANE, {29'h0, 1'b1, 2'(w)});
                wcyc(3);
                check("io_oe out", io_oe, {28'h0, exp_oe(2'(w), q[0])});
                recv_byte((exp_oe(2'(w), q[0]) == 4'hF) ? 4 : (w != 0) ? 2 : 1, got);
                check("tx byte", got, {24'h0, b});
                wreg(SFPI_OFF_LANE, 32'h0);
                wcyc(3);
                check("io_oe off", io_oe, 32'h0);
                host.close_frame();
                check("io_oe rel", io_oe, 32'h0);
            end
        end
        // busy internal operation holds off standby
        wreg(SFPI_OFF_CTRL, 32'h0);
        wreg(SFPI_OFF_OPCTL, 32'h1);
        host.open_frame();
        host.close_frame();
        wcyc(20);
        check("standby busy", standby, 32'h0);
        wreg(SFPI_OFF_OPCTL, 32'h2);
        wait_stby();
        check("standby done", standby, 32'h1);
        // deep power-down only when requested
        wreg(SFPI_OFF_CTRL, 32'h10);
        host.open_frame();
        host.close_frame();
        wcyc(6);
        rreg(SFPI_OFF_STATUS, v);
        check("dpd", v[SFPI_ST_DPD], 32'h1);
        // write protect decode, random configs and pin states
        for (int k = 0; k < 12; k++) begin
            c = (k == 0) ? 5'h02 : {2'h0, 3'($random(seed))};
            wp = (k == 0) ? 1'b0 : 1'($random(seed));
            fl = (k == 0) ? 1'b0 : 1'($random(seed));
            wreg(SFPI_OFF_CTRL, {27'h0, c});
            host.drive({1'b0, wp, 2'h0}, {1'b0, ~fl, 2'h0});
            wcyc(6);
            rreg(SFPI_OFF_STATUS, v);
            check("wp block", v[SFPI_ST_WPB], {31'h0, exp_wpb(c, fl | wp)});
        end
        // pin three as reset, then as hold
        wreg(SFPI_OFF_CTRL, 32'h08);
        host.drive(4'h0, 4'h8);
        wcyc(6);
        rreg(SFPI_OFF_STATUS, v);
        check("pin reset", v[SFPI_ST_PRST], 32'h1);
        check("standby rst", standby, 32'h1);
        host.drive(4'h0, 4'h0);
        wreg(SFPI_OFF_CTRL, 32'h0);
        host.open_frame();
        host.drive(4'h0, 4'h8);
        wcyc(6);
        rreg(SFPI_OFF_STATUS, v);
        check("hold on", v[SFPI_ST_HOLD], 32'h1);
        host.drive(4'h0, 4'h0);
        wcyc(6);
        rreg(SFPI_OFF_STATUS, v);
        check("hold off", v[SFPI_ST_HOLD], 32'h0);
        host.close_frame();
        finish_test();
    end
endmodule
`default_nettype wire
